// *** rtl/spb_map.vh ***
// constants for the separate-port burst sram
// Contract
// R01: read latency is 1.5 cycles with dll enabled, 1 cycle with it off.
// R02: accesses start only on positive input clock rises.
// R03: write words are captured on rises of both input clocks.
// R04: read data launch on output clock rises, input clocks in single mode.
// R05: read stores address, then four words, lowest first on negative clock; with dll off the core launches it on the positive clock.
// R06: a read request right after a read start is ignored.
// R07: read deselect finishes burst then tristates after next positive rise.
// R08: write captures four words over two cycles, then commits 72 bits.
// R09: a write request right after a write start is ignored.
// R10: write deselect completes pending burst then ignores write inputs.
// R11: byte write selects are sampled with every write word.
// R12: select 0 gates bits 8:0, select 1 gates bits 17:9.
// R13: both output clocks high at power-on strap single clock mode.
// R14: two free-running echo strobes follow the output clock pair.
// R15: reads return newest data, forwarding from in-flight writes.
// R16: both selects low: read unless previous cycle started a read.
// R17: controller starts at most one transaction per clock cycle.
// R18: port selects are sampled only on positive input clock rises.
// R19: deselecting one port leaves the other port running.
// R20: output impedance is re-adjusted once every 1024 clock cycles.
// R21: memory is four arrays of 1M x 18, one per burst word.
// R22: powers up with ports deselected and read outputs tristated.
// R23: burst words run sequentially from A through A+3.
// R24: read outputs stay high impedance when idle and unselected.
`ifndef SPB_MAP_VH
`define SPB_MAP_VH
`define SPB_AW 20
`define SPB_DW 18
`define SPB_BW 72
`define SPB_LANES 8
`define SPB_LANE_W 9
`define SPB_DEPTH 1048576
`define SPB_ZQ_PERIOD 1024
`define SPB_ZQ_LAST 10'h3ff
`define SPB_FIFO_W 100
`endif

// *** rtl/spb_mem.v ***
// four 1M x 18 arrays, one per burst word, with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "spb_map.vh"
module spb_mem (
  input wire i_mclk,
  input wire i_we,
  input wire i_re,
  input wire [`SPB_AW-1:0] i_addr,
  input wire [`SPB_BW-1:0] i_wdata,
  input wire [`SPB_LANES-1:0] i_wlane,
  output wire [`SPB_BW-1:0] o_rdata
);
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : arr
      reg [`SPB_DW-1:0] mem [0:`SPB_DEPTH-1];
      reg [`SPB_DW-1:0] rd;
      always @(posedge i_mclk)
      begin
        if (i_we && i_wlane[2*g])
          mem[i_addr][8:0] <= i_wdata[g*18 +: 9]; // [R21]
        if (i_we && i_wlane[2*g+1])
          mem[i_addr][17:9] <= i_wdata[g*18+9 +: 9];
        if (i_re)
          rd <= mem[i_addr];
      end
      assign o_rdata[g*18 +: 18] = rd;
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/spb_fifo2.v ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "spb_map.vh"
module spb_fifo2 (
  input wire i_mclk,
  input wire i_rst,
  input wire i_valid,
  output wire o_ready,
  input wire [`SPB_FIFO_W-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [`SPB_FIFO_W-1:0] o_data
);
  reg [`SPB_FIFO_W-1:0] ent0;
  reg [`SPB_FIFO_W-1:0] ent1;
  reg [1:0] count;
  wire push = i_valid && (count != 2'd2);
  wire pop = i_ready && (count != 2'd0);
  assign o_ready = (count != 2'd2);
  assign o_valid = (count != 2'd0);
  assign o_data = ent0;
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      count <= 2'd0;
      ent0 <= {`SPB_FIFO_W{1'b0}};
      ent1 <= {`SPB_FIFO_W{1'b0}};
    end
    else
    begin
      if (pop)
      begin
        ent0 <= ent1;
        if (push && count == 2'd1)
          ent0 <= i_data;
        else if (push)
          ent1 <= i_data;
      end
      else if (push)
      begin
        if (count == 2'd0)
          ent0 <= i_data;
        else
          ent1 <= i_data;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// *** rtl/spb_top.v ***
// separate-port burst sram core: arbitration, write capture, read launch
`timescale 1ns/1ps
`default_nettype none
`include "spb_map.vh"
module spb_top (
  input wire i_mclk,
  input wire i_rst,
  input wire i_k,
  input wire i_k_n,
  input wire i_c,
  input wire i_c_n,
  input wire i_read_port_select_n,
  input wire i_write_port_select_n,
  input wire [1:0] i_byte_write_select_n,
  input wire [`SPB_AW-1:0] i_addr,
  input wire [`SPB_DW-1:0] i_wdata,
  input wire i_dll_disable_n,
  output reg [`SPB_DW-1:0] o_read_data,
  output reg o_read_data_oe,
  output reg o_echo_strobe,
  output reg o_echo_strobe_n,
  output reg o_impedance_update,
  output reg o_single_clock
);
  // lane-wise merge of new bytes over old ones
  function [`SPB_BW-1:0] mrg;
    input [`SPB_BW-1:0] base;
    input [`SPB_BW-1:0] upd;
    input [`SPB_LANES-1:0] lane;
    integer i;
    begin
      mrg = base;
      for (i = 0; i < `SPB_LANES; i = i + 1)
        if (lane[i])
          mrg[i*9 +: 9] = upd[i*9 +: 9];
    end
  endfunction

  function [`SPB_DW-1:0] word_of;
    input [`SPB_BW-1:0] buff;
    input [1:0] idx;
    begin
      word_of = buff[idx*18 +: 18];
    end
  endfunction

  // clock edge detection on sampled timing pins
  reg k_q;
  reg kn_q;
  reg op_q;
  reg on_q;
  reg strap_done;
  wire op_clk = o_single_clock ? i_k : i_c;
  wire on_clk = o_single_clock ? i_k_n : i_c_n;
  wire k_rise = i_k && !k_q;
  wire kn_rise = i_k_n && !kn_q;
  wire op_rise = op_clk && !op_q; // [R04]
  wire on_rise = on_clk && !on_q;
  wire dll_off = !i_dll_disable_n;

  // arbitration
  reg prev_read;
  reg prev_write;
  wire rsel = !i_read_port_select_n;
  wire wsel = !i_write_port_select_n;
  // read wins unless the last rise started one; selects seen on k only
  wire start_read = k_rise && rsel && !prev_read; // [R02] [R06] [R16] [R18]
  wire start_write = k_rise && wsel && !prev_write
    && !start_read; // [R09] [R16] [R17]

  // write capture
  reg wq_valid;
  reg [`SPB_AW-1:0] wq_addr;
  reg [`SPB_AW-1:0] waddr;
  reg [2:0] wcnt;
  reg [`SPB_BW-1:0] wdat;
  reg [`SPB_LANES-1:0] wmask;
  reg [3:0] wvalid;
  reg cmt_pend;
  wire cap_k = k_rise && ((wcnt == 3'd0 && wq_valid) || wcnt == 3'd2);
  wire cap_kn = kn_rise && (wcnt == 3'd1 || wcnt == 3'd3);
  wire cap_en = cap_k || cap_kn; // [R03]
  wire [1:0] cap_idx = wcnt[1:0];
  wire [`SPB_AW-1:0] cap_addr = (wcnt == 3'd0) ? wq_addr : waddr;
  wire [`SPB_LANES-1:0] cap_lane =
    {6'h00, ~i_byte_write_select_n} << {cap_idx, 1'b0}; // [R11] [R12]
  wire [`SPB_BW-1:0] cap_data = {4{i_wdata}};
  wire [`SPB_LANES-1:0] wlane_ok =
    wmask & {{2{wvalid[3]}}, {2{wvalid[2]}}, {2{wvalid[1]}}, {2{wvalid[0]}}};

  // commit buffer and array
  wire fifo_ready;
  wire fifo_valid;
  wire [`SPB_FIFO_W-1:0] fifo_out;
  wire [`SPB_BW-1:0] mem_rdata;
  wire mem_we = fifo_valid && !start_read;
  wire [`SPB_AW-1:0] mem_addr = start_read ? i_addr
    : fifo_out[`SPB_FIFO_W-1 -: 20];

  spb_fifo2 u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(cmt_pend),
    .o_ready(fifo_ready),
    .i_data({waddr, wdat, wmask}), // [R08]
    .o_valid(fifo_valid),
    .i_ready(!start_read),
    .o_data(fifo_out)
  );

  spb_mem u_mem (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_re(start_read),
    .i_addr(mem_addr),
    .i_wdata(fifo_out[79:8]),
    .i_wlane(fifo_out[7:0]),
    .o_rdata(mem_rdata)
  );

  // read path
  reg [`SPB_AW-1:0] raddr;
  reg [`SPB_BW-1:0] rbuf;
  reg rload;
  reg rarm;
  reg rgo;
  reg [`SPB_BW-1:0] osh;
  reg [`SPB_AW-1:0] oaddr;
  reg [1:0] oidx;
  reg oactive;
  reg [9:0] zcnt;
  reg [`SPB_BW-1:0] rbase;
  reg [`SPB_BW-1:0] next_rbuf;
  reg [`SPB_BW-1:0] next_osh;

  // forward in-flight write bytes so a read sees the newest data
  always @*
  begin
    rbase = rload ? ((waddr == raddr) ? mrg(mem_rdata, wdat, wlane_ok)
      : mem_rdata) : rbuf; // [R15]
    next_rbuf = (cap_en && cap_addr == raddr) ?
      mrg(rbase, cap_data, cap_lane) : rbase; // [R15]
    next_osh = (cap_en && cap_addr == oaddr) ?
      mrg(osh, cap_data, cap_lane) : osh;
  end

  wire rgo_now = rgo || (rarm && k_rise);
  // lowest word goes out on the negative clock with dll on, else positive
  wire first = rgo_now && (dll_off ? op_rise : on_rise); // [R01] [R05]
  wire out_edge = op_rise || on_rise;

  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      // seeded high so an idle-high pin gives no false rise after reset
      k_q <= 1'b1;
      kn_q <= 1'b1;
      op_q <= 1'b1;
      on_q <= 1'b1;
      strap_done <= 1'b0;
      o_single_clock <= 1'b0;
      prev_read <= 1'b0;
      prev_write <= 1'b0;
      wq_valid <= 1'b0;
      wq_addr <= {`SPB_AW{1'b0}};
      waddr <= {`SPB_AW{1'b0}};
      wcnt <= 3'd0;
      wdat <= {`SPB_BW{1'b0}};
      wmask <= 8'h00;
      wvalid <= 4'h0;
      cmt_pend <= 1'b0;
      raddr <= {`SPB_AW{1'b0}};
      rbuf <= {`SPB_BW{1'b0}};
      rload <= 1'b0;
      rarm <= 1'b0;
      rgo <= 1'b0;
      osh <= {`SPB_BW{1'b0}};
      oaddr <= {`SPB_AW{1'b0}};
      oidx <= 2'd0;
      oactive <= 1'b0;
      o_read_data <= {`SPB_DW{1'b0}};
      o_read_data_oe <= 1'b0; // [R22]
      o_echo_strobe <= 1'b0;
      o_echo_strobe_n <= 1'b0;
      zcnt <= 10'h000;
      o_impedance_update <= 1'b0;
    end
    else
    begin
      k_q <= i_k;
      kn_q <= i_k_n;
      op_q <= op_clk;
      on_q <= on_clk;
      // strap caught once after reset release, then frozen
      if (!strap_done)
      begin
        strap_done <= 1'b1;
        o_single_clock <= i_c && i_c_n; // [R13]
      end
      // echo strobes run free off whichever pair drives the outputs
      o_echo_strobe <= op_clk; // [R14]
      o_echo_strobe_n <= on_clk; // [R14]
      if (k_rise)
      begin
        prev_read <= start_read;
        prev_write <= start_write;
      end
      if (k_rise)
        zcnt <= zcnt + 10'h001;
      o_impedance_update <= k_rise && zcnt == `SPB_ZQ_LAST; // [R20]

      // write side keeps running whatever the read port does
      if (cmt_pend && fifo_ready)
        cmt_pend <= 1'b0;
      if (cap_en) // [R10] [R19]
      begin
        wdat[cap_idx*18 +: 18] <= i_wdata; // [R03] [R23]
        wmask[cap_idx*2 +: 2] <= ~i_byte_write_select_n; // [R11]
        if (cap_idx == 2'd0)
        begin
          waddr <= wq_addr;
          wq_valid <= 1'b0;
          wvalid <= 4'h1;
        end
        else
          wvalid <= wvalid | (4'h1 << cap_idx);
        if (cap_idx == 2'd3)
        begin
          wcnt <= 3'd0;
          cmt_pend <= 1'b1; // [R08]
        end
        else
          wcnt <= wcnt + 3'd1;
      end
      if (start_write)
      begin
        wq_valid <= 1'b1;
        wq_addr <= i_addr;
      end

      // read side
      rload <= start_read;
      rbuf <= next_rbuf;
      if (start_read)
      begin
        raddr <= i_addr; // [R05]
        rarm <= 1'b1;
      end
      else if (rarm && k_rise)
      begin
        rarm <= 1'b0;
        rgo <= 1'b1;
      end
      osh <= next_osh;
      if (first)
      begin
        rgo <= 1'b0;
        osh <= next_rbuf;
        oaddr <= raddr;
        o_read_data <= word_of(next_rbuf, 2'd0); // [R05] [R23]
        o_read_data_oe <= 1'b1;
        oidx <= 2'd1;
        oactive <= 1'b1;
      end
      else if (oactive && out_edge)
      begin
        o_read_data <= word_of(next_osh, oidx); // [R04] [R23]
        oidx <= oidx + 2'd1;
        if (oidx == 2'd3)
          oactive <= 1'b0;
      end
      else if (op_rise && !oactive && !rgo_now)
        o_read_data_oe <= 1'b0; // [R07] [R24]
    end
  end
endmodule
`default_nettype wire

// *** tb/spb_ctl_model.sv ***
// controller-side timing clock generator for the burst sram
`timescale 1ns/1ps
`default_nettype none
module spb_ctl_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  output logic [2:0] o_phase,
  output logic o_k,
  output logic o_k_n,
  output logic o_c,
  output logic o_c_n
);
  // each level lasts four cycles so the core samples every rise once
  always @(posedge i_mclk)
    o_phase <= i_rst ? 3'h0 : o_phase + 3'h1;
  assign o_k = o_phase[2];
  assign o_k_n = ~o_phase[2];
  // zero skew pair, never both high, so the strap picks dual clocks
  assign o_c = o_phase[2];
  assign o_c_n = ~o_phase[2];
endmodule
`default_nettype wire

// *** tb/spb_top_sva.sv ***
// assertions on the burst sram core ports
`timescale 1ns/1ps
`default_nettype none
`include "spb_map.vh"
module spb_top_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_k,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_read_port_select_n,
  input wire logic [`SPB_DW-1:0] o_read_data,
  input wire logic o_read_data_oe,
  input wire logic o_echo_strobe,
  input wire logic o_echo_strobe_n,
  input wire logic o_impedance_update,
  input wire logic o_single_clock
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_echo_pos: assert property (!$past(i_rst, 2) && !o_single_clock
    |-> o_echo_strobe == $past(i_c)) else $error("echo strobe off");
  a_echo_neg: assert property (!$past(i_rst, 2) && !o_single_clock
    |-> o_echo_strobe_n == $past(i_c_n)) else $error("echo strobe_n off");
  a_oe_after_reset: assert property ($fell(i_rst)
    |-> !o_read_data_oe [*4]) else $error("outputs driven after reset");
  a_imp_one_pulse: assert property (o_impedance_update
    |=> !o_impedance_update [*8]) else $error("impedance pulse too long");
  a_read_first_word: assert property ($rose(i_k) && !i_read_port_select_n
    |-> ##[9:16] o_read_data_oe) else $error("read data late");
  a_oe_off_on_rise: assert property ($fell(o_read_data_oe) && !o_single_clock
    |-> $past(i_c) && !$past(i_c, 2)) else $error("tristate off edge");
  a_word_on_clock: assert property ($changed(o_read_data) && o_read_data_oe
    && !o_single_clock |-> ($past(i_c) && !$past(i_c, 2))
    || ($past(i_c_n) && !$past(i_c_n, 2))) else $error("word off edge");
  a_strap_fixed: assert property (!$past(i_rst, 2)
    |-> $stable(o_single_clock)) else $error("strap changed");
endmodule
bind spb_top spb_top_sva u_sva (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_k(i_k), .i_c(i_c), .i_c_n(i_c_n),
  .i_read_port_select_n(i_read_port_select_n), .o_read_data(o_read_data),
  .o_read_data_oe(o_read_data_oe), .o_echo_strobe(o_echo_strobe),
  .o_echo_strobe_n(o_echo_strobe_n),
  .o_impedance_update(o_impedance_update), .o_single_clock(o_single_clock));
`default_nettype wire

// *** tb/spb_top_tb.sv ***
// self-checking bench for the burst sram core
`timescale 1ns/1ps
`default_nettype none
`include "spb_map.vh"
module spb_top_tb;
  logic i_mclk = 1'h0;
  logic i_rst = 1'h1;
  logic rsel_n = 1'h1;
  logic wsel_n = 1'h1;
  logic dll_n = 1'h1;
  logic [1:0] bws_n = 2'h3;
  logic [`SPB_AW-1:0] addr = '0;
  logic [`SPB_DW-1:0] wdata = '0;
  logic [2:0] ph;
  logic k, k_n, c, c_n, oe, es, es_n, imp, single;
  logic [`SPB_DW-1:0] rdata;
  logic [71:0] q;
  int num_errors = 0;
  int checked = 0;
  int n_on, n_off;
  always #10 i_mclk = ~i_mclk;
  spb_ctl_model u_ctl (.i_mclk(i_mclk), .i_rst(i_rst), .o_phase(ph),
    .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n));
  spb_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_k(k), .i_k_n(k_n),
    .i_c(c), .i_c_n(c_n), .i_read_port_select_n(rsel_n),
    .i_write_port_select_n(wsel_n), .i_byte_write_select_n(bws_n),
    .i_addr(addr), .i_wdata(wdata), .i_dll_disable_n(dll_n),
    .o_read_data(rdata), .o_read_data_oe(oe), .o_echo_strobe(es),
    .o_echo_strobe_n(es_n), .o_impedance_update(imp),
    .o_single_clock(single));
  task automatic chk(input string nm, input logic [71:0] e, s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // drive just after the edge whose pre-edge phase is v
  task automatic drv(input logic [2:0] v);
    do @(negedge i_mclk); while (ph !== v);
    @(posedge i_mclk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [71:0] d,
    input logic [7:0] b);
    drv(3'h3);
    wsel_n <= 1'h0;
    addr <= a;
    for (int i = 0; i < 4; i++)
    begin
      drv(i[0] ? 3'h7 : 3'h3);
      wsel_n <= 1'h1;
      wdata <= d[18*i +: 18];
      bws_n <= b[2*i +: 2];
    end
  endtask
  task automatic rd(input logic [19:0] a, output logic [71:0] r,
    output int n);
    n = 0;
    drv(3'h3);
    rsel_n <= 1'h0;
    addr <= a;
    drv(3'h3);
    rsel_n <= 1'h1;
    while (oe !== 1'h1 && n < 40)
    begin
      @(negedge i_mclk);
      n++;
    end
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0)
        repeat (4) @(negedge i_mclk);
      r[18*i +: 18] = rdata;
    end
    repeat (10) @(negedge i_mclk);
    chk("oe idle", 72'h0, {71'h0, oe});
  endtask
  task automatic t_reset;
    chk("oe at reset", 72'h0, {71'h0, oe});
    chk("strap", 72'h0, {71'h0, single});
    $display("test reset done");
  endtask
  task automatic t_burst;
    wr(20'h0_0040, 72'h01_2345_6789_abcd_ef01, 8'h00);
    rd(20'h0_0040, q, n_on);
    chk("burst", 72'h01_2345_6789_abcd_ef01, q);
    $display("test burst done");
  endtask
  // lanes: word0 both, word1 none, word2 upper, word3 lower
  task automatic t_bytes;
    logic [71:0] d, e;
    logic [7:0] m;
    d = 72'hc3_a5a5_f00f_5a5a_0ff0;
    m = 8'h9c;
    for (int i = 0; i < 8; i++)
      e[9*i +: 9] = m[i] ? 72'h01_2345_6789_abcd_ef01 >> (9*i)
        : d[9*i +: 9];
    wr(20'h0_0040, d, m);
    rd(20'h0_0040, q, n_on);
    chk("byte mask", e, q);
    @(posedge i_mclk);
    dll_n <= 1'h0;
    rd(20'h0_0040, q, n_off);
    chk("dll off data", e, q);
    chk("latency gap", 72'h4, 72'(n_on - n_off));
    @(posedge i_mclk);
    dll_n <= 1'h1;
    $display("test bytes done");
  endtask
  // read issued on the rise right after the write start
  task automatic t_fwd;
    int n;
    fork
      wr(20'h0_0080, 72'hfe_dcba_9876_5432_10fe, 8'h00);
      begin
        drv(3'h3);
        rd(20'h0_0080, q, n);
      end
    join
    chk("forward", 72'hfe_dcba_9876_5432_10fe, q);
    $display("test forward done");
  endtask
  task automatic t_imp;
    int n;
    n = 0;
    while (imp !== 1'h1 && n < 20000)
    begin
      @(negedge i_mclk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge i_mclk);
      n++;
    end
    while (imp !== 1'h1 && n < 20000);
    chk("impedance period", 72'(8 * 1024), 72'(n));
    $display("test impedance done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // the impedance wait alone needs up to two full periods
  initial
  begin
    repeat (40000) @(posedge i_mclk);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'h0;
    repeat (3) @(negedge i_mclk);
    t_reset();
    t_burst();
    t_bytes();
    t_fwd();
    t_imp();
    conclude();
  end
endmodule
`default_nettype wire
